// file: inc/key_slot_pkg.sv
// Package for the key-slot selection and interrupt register bank.
// Assumes a 32-bit APB slave with byte addresses equal to register offsets.
package key_slot_pkg;

    // Register byte offsets.
    localparam logic [11:0] OFF_IRQ_ENABLE_DIRECT = 12'h300;
    localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] OFF_IRQ_PENDING_VIEW = 12'h30C;
    localparam logic [11:0] OFF_EVENT_FLAGS = 12'h100;
    localparam logic [11:0] OFF_SELECTION_OUTCOME = 12'h40C;
    localparam logic [11:0] OFF_SLOT_CHOICE = 12'h500;

    // Event bit positions.
    localparam int BIT_PUSHED = 0;
    localparam int BIT_REVOKED = 1;
    localparam int BIT_FAULT = 2;
    localparam int NUM_EVENTS = 3;

    // Status bit positions.
    localparam int BIT_SELECTED = 0;
    localparam int BIT_BLOCKED = 1;

    // Reset values.
    localparam logic [2:0] RST_ENABLE = 3'h0;
    localparam logic [31:0] RST_SLOT = 32'h00000000;
    localparam logic [1:0] RST_STATUS = 2'h0;

    // Identifier that selects no slot.
    localparam logic [31:0] SLOT_NONE = 32'h00000000;

    // Events reported by the key store and push datapath.
    typedef struct packed {
        logic fault;
        logic revoked;
        logic pushed;
    } slot_events_t;

    // Outcome of a selection, as reported by the key store.
    typedef struct packed {
        logic blocked;
        logic selected;
    } select_outcome_t;

endpackage : key_slot_pkg

// file: verilog/slot_table.sv
// Small table of slot-valid bits, one per configuration index.
// Assumes a single clock; read data are registered.
`timescale 1ns/10ps
module slot_table
    import key_slot_pkg::*;
#(
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Write port.
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrIdx,
    input wire logic wrValid,
    // Read port.
    input wire logic [$clog2(DEPTH)-1:0] rdIdx,
    output logic rdValid
);

    // A table of one entry cannot tell slots apart, so refuse it at elaboration.
    if (DEPTH < 2) begin : g_bad_depth
        $error("DEPTH must be at least 2");
    end

    logic [DEPTH-1:0] mem_q;

    // Storage of the valid flags; cleared at reset so no slot is usable.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_q <= '0;
        end else if (wrEn) begin
            mem_q[wrIdx] <= wrValid;
        end
    end

    // Registered read.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= mem_q[rdIdx];
        end
    end

endmodule : slot_table

// file: verilog/key_slot_regs.sv
// Notes on behaviour
// - Set view writes one to enable
// - Clear view writes one to disable
// - Pending view is read only
// - Selection write clears then updates status
// - Selected bit shows successful selection
// - Blocked bit shows detected access violation
// - Slot choice register holds chosen identifier
// - Identifier zero selects no slot
// - Configuration index N is identifier N+1
// - Direct enable register writes all enables
// - Fault raised on push without slot
//
// Register bank of the key manager: interrupt enables, event flags,
// selection status and slot choice, reached over APB.
// Assumes event and access inputs come from logic on ref_clk.
`timescale 1ns/10ps
module key_slot_regs
    import key_slot_pkg::*;
#(
    parameter int NUM_SLOTS = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath events and slot configuration.
    input wire slot_events_t eventIn,
    input wire logic pushRequest,
    input wire logic destDefined,
    input wire logic accessViolation,
    input wire logic cfgWrEn,
    input wire logic [$clog2(NUM_SLOTS)-1:0] cfgIdx,
    input wire logic cfgValid,
    // Outputs to the datapath and processor.
    output logic [31:0] slotChoice,
    output logic slotSelected,
    output logic irq
);

    localparam int IW = $clog2(NUM_SLOTS);

    // Refuse slot counts that the index decode cannot serve, at elaboration.
    if (NUM_SLOTS < 2 || NUM_SLOTS > 255) begin : g_bad_slots
        $error("NUM_SLOTS out of range");
    end

    logic [2:0] enable_q;
    logic [2:0] flags_q;
    logic [31:0] slot_q;
    select_outcome_t status_q;
    logic evalPending_q;
    logic [31:0] evalId_q;
    logic tableValid;
    logic [IW-1:0] lookupIdx;
    logic [2:0] raise;
    logic [2:0] pending;
    logic wrAcc;
    logic rdAcc;

    // Access decode; every transfer completes in its first access cycle.
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign pready = 1'b1;

    // Map identifier to configuration index (identifier minus one).
    function automatic logic [IW-1:0] id_to_index(input logic [31:0] id);
        logic [31:0] t;
        t = id - 32'h00000001;
        return t[IW-1:0];
    endfunction : id_to_index

    // True when an identifier names a slot that exists.
    function automatic logic id_in_range(input logic [31:0] id);
        return (id != SLOT_NONE) && (id <= 32'(NUM_SLOTS));
    endfunction : id_in_range

    // Unmapped addresses give an error response.
    always_comb begin
        case (paddr)
            OFF_IRQ_ENABLE_DIRECT, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR,
            OFF_IRQ_PENDING_VIEW, OFF_EVENT_FLAGS, OFF_SELECTION_OUTCOME,
            OFF_SLOT_CHOICE: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // Enable bits; the three views share one register.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_q <= RST_ENABLE;
        end else if (wrAcc) begin
            if (paddr == OFF_IRQ_ENABLE_DIRECT) begin
                enable_q <= pwdata[2:0];
            end
            if (paddr == OFF_IRQ_ENABLE_SET) begin
                enable_q <= enable_q | pwdata[2:0];
            end
            if (paddr == OFF_IRQ_ENABLE_CLEAR) begin
                enable_q <= enable_q & ~pwdata[2:0];
            end
        end
    end

    always_comb begin
        raise = {eventIn.fault, eventIn.revoked, eventIn.pushed};
        if (pushRequest && (slot_q == SLOT_NONE || !destDefined)) begin
            raise[BIT_FAULT] = 1'b1;
        end
    end

    // Sticky event flags, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '0;
        end else if (wrAcc && paddr == OFF_EVENT_FLAGS) begin
            flags_q <= (flags_q & ~pwdata[2:0]) | raise;
        end else begin
            flags_q <= flags_q | raise;
        end
    end

    assign pending = flags_q & enable_q;
    assign irq = |pending;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slot_q <= RST_SLOT;
        end else if (wrAcc && paddr == OFF_SLOT_CHOICE) begin
            slot_q <= pwdata;
        end
    end
    assign slotChoice = slot_q;

    assign lookupIdx = id_to_index(pwdata);

    slot_table #(
        .DEPTH(NUM_SLOTS)
    ) u_table (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wrEn(cfgWrEn),
        .wrIdx(cfgIdx),
        .wrValid(cfgValid),
        .rdIdx(lookupIdx),
        .rdValid(tableValid)
    );

    // Track the selection whose table lookup is in flight.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evalPending_q <= 1'b0;
            evalId_q <= SLOT_NONE;
        end else begin
            evalPending_q <= wrAcc && paddr == OFF_SLOT_CHOICE;
            evalId_q <= pwdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= RST_STATUS;
        end else if (wrAcc && paddr == OFF_SLOT_CHOICE) begin
            status_q <= RST_STATUS;
        end else if (evalPending_q) begin
            status_q.selected <= id_in_range(evalId_q) && tableValid;
            status_q.blocked <= accessViolation;
        end else if (accessViolation) begin
            status_q.blocked <= 1'b1;
        end
    end
    assign slotSelected = status_q.selected;

    // Read data; reserved bits read as zero.
    // pending read only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_IRQ_ENABLE_DIRECT: prdata <= {29'h0, enable_q};
                OFF_IRQ_ENABLE_SET: prdata <= {29'h0, enable_q};
                OFF_IRQ_ENABLE_CLEAR: prdata <= {29'h0, enable_q};
                OFF_IRQ_PENDING_VIEW: prdata <= {29'h0, pending};
                OFF_EVENT_FLAGS: prdata <= {29'h0, flags_q};
                OFF_SELECTION_OUTCOME: prdata <= {30'h0, status_q};
                OFF_SLOT_CHOICE: prdata <= slot_q;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Checks.
    chk_set_view_or: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_IRQ_ENABLE_SET |=> (enable_q & $past(pwdata[2:0])) == $past(pwdata[2:0]))
        else $error("set view did not enable");
    chk_clr_view_and: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_IRQ_ENABLE_CLEAR |=> (enable_q & $past(pwdata[2:0])) == 3'h0)
        else $error("clear view did not disable");
    chk_pending_stable: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_IRQ_PENDING_VIEW && raise == 3'h0
        |=> $stable(flags_q) && $stable(enable_q))
        else $error("pending view write changed state");
    chk_status_cleared: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_SLOT_CHOICE |=> status_q == RST_STATUS)
        else $error("status not cleared on selection");
    chk_zero_unselected: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_SLOT_CHOICE && pwdata == SLOT_NONE |=> ##1 !status_q.selected)
        else $error("zero identifier selected a slot");
    chk_slot_held: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrAcc && paddr == OFF_SLOT_CHOICE |=> slot_q == $past(pwdata))
        else $error("slot choice not stored");
    chk_fault_raised: assert property (@(posedge ref_clk) disable iff (!rstn)
        pushRequest && slot_q == SLOT_NONE |=> flags_q[BIT_FAULT])
        else $error("fault not raised on empty push");
    chk_irq_pending: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq == ((flags_q & enable_q) != 3'h0))
        else $error("interrupt does not match pending");
    chk_blocked_seen: assert property (@(posedge ref_clk) disable iff (!rstn)
        accessViolation && !(wrAcc && paddr == OFF_SLOT_CHOICE) |=> status_q.blocked)
        else $error("violation not reported");
    cov_select: cover property (@(posedge ref_clk) disable iff (!rstn)
        evalPending_q ##1 status_q.selected);
    cov_irq: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(irq));
    cov_fault: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(flags_q[BIT_FAULT]));

endmodule : key_slot_regs

// file: testbench/test_key_slot_regs.sv
// Self-checking bench for the key-slot register bank, driven as an APB master.
// Assumes the bank answers with pready and holds read data through the access phase.
`timescale 1ns/10ps
module test_key_slot_regs;
    import key_slot_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, slotChoice, r, slot = 32'h0;
    slot_events_t eventIn = '0;
    logic pushRequest = 1'b0, destDefined = 1'b0, accessViolation = 1'b0;
    logic cfgWrEn = 1'b0, cfgValid = 1'b0, slotSelected, irq, sel = 1'b0;
    logic [2:0] cfgIdx = 3'h0;
    logic [7:0] valid = 8'h00;
    logic [15:0] lf = 16'h0010;
    int errCount = 0, nChecks = 0, en = 0, flg = 0, blk = 0;
    logic [31:0] ids[6];

    key_slot_regs #(.NUM_SLOTS(8)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eventIn(eventIn), .pushRequest(pushRequest),
        .destDefined(destDefined), .accessViolation(accessViolation), .cfgWrEn(cfgWrEn),
        .cfgIdx(cfgIdx), .cfgValid(cfgValid), .slotChoice(slotChoice),
        .slotSelected(slotSelected), .irq(irq));

    // The clock toggles every half period of 20 ns.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic conclude();
        if (errCount == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Wait for the answer however long it takes; only the watchdog ends a hang.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp, "read data");
    endtask : rd

    // Writing the choice clears status, then the outcome lands one edge later.
    task automatic pick(input logic [31:0] id);
        apb(1'b1, OFF_SLOT_CHOICE, id);
        slot = id;
        blk = 0;
        sel = id >= 32'h1 && id <= 32'h8 && valid[3'(id - 32'h1)];
        @(posedge ref_clk);
        rd(OFF_SELECTION_OUTCOME, {30'h0, blk[0], sel});
        chk(slotSelected, sel, "selected output");
        rd(OFF_SLOT_CHOICE, id);
        chk(slotChoice, id, "slot output");
    endtask : pick

    task automatic pulse(input logic [2:0] v);
        eventIn <= v;
        @(posedge ref_clk);
        eventIn <= '0;
        @(posedge ref_clk);
        flg |= v;
        rd(OFF_IRQ_PENDING_VIEW, flg & en);
        chk(irq, (flg & en) != 0, "irq level");
    endtask : pulse

    task automatic push(input logic dest);
        destDefined <= dest;
        pushRequest <= 1'b1;
        @(posedge ref_clk);
        pushRequest <= 1'b0;
        repeat (3) @(posedge ref_clk);
        flg = 4;
        rd(OFF_EVENT_FLAGS, flg);
        apb(1'b1, OFF_EVENT_FLAGS, 32'h7);
        flg = 0;
    endtask : push

    // A hang counts as a mismatch and closes the run.
    initial begin
        #400000;
        errCount++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        ids = '{OFF_IRQ_ENABLE_DIRECT, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR,
            OFF_IRQ_PENDING_VIEW, OFF_SELECTION_OUTCOME, OFF_SLOT_CHOICE};
        foreach (ids[i]) rd(ids[i][11:0], 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            apb(1'b1, k[0] ? OFF_IRQ_ENABLE_CLEAR : OFF_IRQ_ENABLE_SET, {16'h0, lf});
            en = k[0] ? en & ~int'(lf[2:0]) : en | int'(lf[2:0]);
            rd(OFF_IRQ_ENABLE_SET, en);
            rd(OFF_IRQ_ENABLE_CLEAR, en);
            rd(OFF_IRQ_ENABLE_DIRECT, en);
        end
        apb(1'b1, OFF_IRQ_ENABLE_DIRECT, 32'h5);
        en = 5;
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            pulse(k < 3 ? 3'(1 << k) : lf[2:0]);
        end
        apb(1'b1, OFF_IRQ_PENDING_VIEW, 32'h7);
        rd(OFF_IRQ_PENDING_VIEW, flg & en);
        apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h7);
        en = 7;
        rd(OFF_IRQ_PENDING_VIEW, flg);
        apb(1'b1, OFF_EVENT_FLAGS, 32'h7);
        flg = 0;
        pulse(3'h0);
        lf = lfsr(lf);
        valid = {lf[7:2], 2'b10};
        for (int i = 0; i < 8; i++) begin
            cfgWrEn <= 1'b1;
            cfgIdx <= 3'(i);
            cfgValid <= valid[i];
            @(posedge ref_clk);
        end
        cfgWrEn <= 1'b0;
        lf = lfsr(lf);
        ids = '{32'h2, 32'h1, 32'h0, 32'h8, 32'h9, {lf, lf}};
        foreach (ids[i]) pick(ids[i]);
        pick(32'h2);
        accessViolation <= 1'b1;
        @(posedge ref_clk);
        accessViolation <= 1'b0;
        @(posedge ref_clk);
        blk = 1;
        rd(OFF_SELECTION_OUTCOME, {30'h0, blk[0], sel});
        pick(32'h2);
        push(1'b0);
        pick(32'h0);
        push(1'b1);
        pick(32'h2);
        pulse(3'h7);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(OFF_IRQ_ENABLE_SET, 32'h0);
        rd(OFF_SLOT_CHOICE, 32'h0);
        rd(OFF_SELECTION_OUTCOME, 32'h0);
        rd(OFF_IRQ_PENDING_VIEW, 32'h0);
        chk(irq, 32'h0, "irq after reset");
        conclude();
    end
endmodule : test_key_slot_regs
